// ===== verilog/pri_core.sv
// Register init, preload, signature store and readback protection core.
// Functional notes
// - Reprogrammable 64-bit user signature store.
// - Signature readable regardless of protection.
// - Checksum covers signature contents.
// - Protected device refuses configuration reads.
// - Protection clears only by full reprogramming.
// - Programming cycle erases automatically first.
// - Preload forces each registered output.
// - Power-up clears registers within 1 us.
// - Registered pins held high, with output enables off, until power-up ends.
// - Floating inputs read as logic one.
`timescale 1ns/1ps
module pri_core (
  input  wire logic                ref_clk,     // System clock, 100 MHz.
  input  wire logic                rst,         // Power-on reset, synchronous high.
  input  wire pri_pkg::pri_prog_s  prog,        // Programmer request.
  input  wire pri_pkg::pri_read_s  rdReq,       // Readback request.
  input  wire logic [7:0]          nextState,   // Next state from the logic array.
  input  wire logic                preloadEn,   // Preload active.
  input  wire logic [7:0]          preloadVal,  // Values forced on preload.
  input  wire logic [7:0]          outEnable,   // Per-cell output enable.
  input  wire logic [7:0]          pinIn,       // Pin input levels.
  input  wire logic [7:0]          pinDriven,   // High where something drives the pin.
  output logic [7:0]               cellQ,       // Register Q values.
  output logic [7:0]               pinOut,      // Registered pin levels.
  output logic [7:0]               pinOe,       // Pin output enables.
  output logic [7:0]               pinRead,     // Pin levels seen by the array.
  output logic [31:0]              rdData,      // Readback data.
  output logic                     rdValid,     // Read answered.
  output logic                     rdRefused,   // Read refused by protection.
  output logic                     progBusy,    // Programming cycle running.
  output logic                     secured,     // Protection cell state.
  output logic [31:0]              checksum,    // Registered checksum.
  output logic                     resetDone    // Power-up reset completed.
);
  pri_pkg::pri_prog_e        progState;
  logic [31:0]               cfgMem [pri_pkg::CFG_WORDS];
  logic [63:0]               sigStore;
  logic [7:0]                pwrCount;
  logic [511:0]              cfgFlat;
  logic [31:0]               next_checksum;
  logic [3:0]                eraseIdx;

  // Power-up counter: output registers stay cleared until it expires.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwrCount  <= 8'h00;
      resetDone <= 1'b0;
    end else if (!resetDone) begin
      if (pwrCount == pri_pkg::PWRUP_CYCLES_W) begin
        resetDone <= 1'b1;
      end
      pwrCount <= pwrCount + 8'h01;
    end
  end

  // Output cells: reset low, preload wins over next-state on the edge.
  always_ff @(posedge ref_clk) begin
    if (rst || !resetDone) begin
      cellQ <= pri_pkg::REG_RESET;
    end else if (preloadEn) begin
      cellQ <= preloadVal;
    end else begin
      cellQ <= nextState;
    end
  end

  // Pins show the inverted Q, so a cleared register drives high.
  always_ff @(posedge ref_clk) begin
    if (rst || !resetDone) begin
      pinOut <= pri_pkg::PULL_HIGH;
      pinOe  <= pri_pkg::REG_RESET;
    end else begin
      pinOut <= ~(preloadEn ? preloadVal : nextState);
      pinOe  <= outEnable;
    end
  end

  // Undriven pins are pulled up and read as one.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinRead <= pri_pkg::PULL_HIGH;
    end else begin
      for (int i = 0; i < pri_pkg::CELL_COUNT; i++) begin
        pinRead[i] <= pinDriven[i] ? pinIn[i] : 1'b1;
      end
    end
  end

  // Programming: one erase pass over the array, then the write.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      progState <= pri_pkg::PRI_IDLE;
      eraseIdx  <= 4'h0;
      progBusy  <= 1'b0;
    end else begin
      unique case (progState)
        pri_pkg::PRI_IDLE: begin
          if (prog.start) begin
            progState <= pri_pkg::PRI_ERASE;
            eraseIdx  <= 4'h0;
            progBusy  <= 1'b1;
          end
        end
        pri_pkg::PRI_ERASE: begin
          eraseIdx <= eraseIdx + 4'h1;
          if (eraseIdx == 4'(pri_pkg::CFG_WORDS - 1)) begin
            progState <= pri_pkg::PRI_WRITE;
          end
        end
        pri_pkg::PRI_WRITE: begin
          progState <= pri_pkg::PRI_IDLE;
          progBusy  <= 1'b0;
        end
        default: begin
          progState <= pri_pkg::PRI_IDLE;
          progBusy  <= 1'b0;
        end
      endcase
    end
  end

  // Configuration storage is nonvolatile, so rst does not touch it.
  always_ff @(posedge ref_clk) begin
    if (progState == pri_pkg::PRI_ERASE) begin
      cfgMem[eraseIdx] <= pri_pkg::CFG_RESET;
    end else if (progState == pri_pkg::PRI_WRITE) begin
      cfgMem[prog.addr] <= prog.data;
    end
  end

  // Signature and protection cell change only inside a programming cycle.
  always_ff @(posedge ref_clk) begin
    if (progState == pri_pkg::PRI_ERASE) begin
      sigStore <= pri_pkg::SIG_RESET;
      secured  <= 1'b0;
    end else if (progState == pri_pkg::PRI_WRITE) begin
      sigStore <= prog.signature;
      secured  <= prog.secure;
    end
  end

  // Reads: signature always served, configuration refused once secured.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData    <= pri_pkg::CFG_RESET;
      rdValid   <= 1'b0;
      rdRefused <= 1'b0;
    end else begin
      rdValid   <= 1'b0;
      rdRefused <= 1'b0;
      if (rdReq.sigRead) begin
        rdData  <= rdReq.addr[0] ? sigStore[63:32] : sigStore[31:0];
        rdValid <= 1'b1;
      end else if (rdReq.cfgRead) begin
        if (secured) begin
          rdData    <= pri_pkg::CFG_RESET;
          rdRefused <= 1'b1;
        end else begin
          rdData  <= cfgMem[rdReq.addr];
          rdValid <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < pri_pkg::CFG_WORDS; i++) begin
      cfgFlat[i*32 +: 32] = cfgMem[i];
    end
  end

  pri_checksum u_checksum (
    .cfgFlat   (cfgFlat),
    .signature (sigStore),
    .checksum  (next_checksum)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      checksum <= pri_pkg::CKS_SEED;
    end else begin
      checksum <= next_checksum;
    end
  end
endmodule : pri_core

// ===== verilog/pri_pkg.sv
// Package with constants and carrier types for the register init and protection block.
package pri_pkg;
  localparam int unsigned CELL_COUNT  = 8;
  localparam int unsigned SIG_BITS    = 64;
  localparam int unsigned CFG_WORDS   = 16;
  localparam int unsigned CFG_AW      = 4;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PWRUP_RESET_NS = 1000;
  localparam int unsigned PWRUP_CYCLES = PWRUP_RESET_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  PWRUP_CYCLES_W = 8'(PWRUP_CYCLES - 1);
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [7:0]  PULL_HIGH   = 8'hFF;
  localparam logic [63:0] SIG_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [31:0] CKS_SEED    = 32'h0000_0000;

  typedef enum logic [2:0] {
    PRI_IDLE  = 3'b001,
    PRI_ERASE = 3'b010,
    PRI_WRITE = 3'b100
  } pri_prog_e;

  typedef struct packed {
    logic        start;
    logic [3:0]  addr;
    logic [31:0] data;
    logic [63:0] signature;
    logic        secure;
  } pri_prog_s;

  typedef struct packed {
    logic        cfgRead;
    logic        sigRead;
    logic [3:0]  addr;
  } pri_read_s;
endpackage : pri_pkg

// ===== verilog/pri_checksum.sv
// Checksum generator folding configuration words and the signature together.
`timescale 1ns/1ps
module pri_checksum (
  input  wire logic [511:0] cfgFlat,   // All configuration words, flattened.
  input  wire logic [63:0]  signature, // Stored user signature.
  output logic      [31:0]  checksum   // Combined checksum.
);
  // Rotate-and-add keeps a single bit change visible in the result.
  function automatic logic [31:0] mix(input logic [31:0] acc, input logic [31:0] word);
    mix = {acc[30:0], acc[31]} + word;
  endfunction : mix

  always_comb begin
    checksum = pri_pkg::CKS_SEED;
    for (int i = 0; i < pri_pkg::CFG_WORDS; i++) begin
      checksum = mix(checksum, cfgFlat[i*32 +: 32]);
    end
    checksum = mix(checksum, signature[31:0]);
    checksum = mix(checksum, signature[63:32]);
  end
endmodule : pri_checksum

// ===== tb/pri_core_props.sv
// Checker of the reset, preload, readback and programming behaviour of the core.
`timescale 1ns/1ps
module pri_core_props (
  input wire logic               ref_clk,    // Clock.
  input wire logic               rst,        // Reset.
  input wire pri_pkg::pri_read_s rdReq,      // Read request.
  input wire logic [7:0]         nextState,  // Array state.
  input wire logic               preloadEn,  // Preload on.
  input wire logic [7:0]         preloadVal, // Preload data.
  input wire logic [7:0]         pinIn,      // Pin levels.
  input wire logic [7:0]         pinDriven,  // Pin driven.
  input wire logic [7:0]         cellQ,      // Cells.
  input wire logic [7:0]         pinOut,     // Pin levels driven.
  input wire logic [7:0]         pinRead,    // Pin view.
  input wire logic [31:0]        rdData,     // Read data.
  input wire logic               rdValid,    // Read done.
  input wire logic               rdRefused,  // Read refused.
  input wire logic               progBusy,   // Busy.
  input wire logic               secured,    // Protected.
  input wire logic               resetDone   // Reset over.
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence busySpan;
    progBusy [*8] ##9 progBusy;
  endsequence
  AST_PRELOAD: assert property (resetDone && preloadEn |=> cellQ == $past(preloadVal))
    else $error("preload value not loaded");
  AST_NEXT: assert property (resetDone && !preloadEn |=> cellQ == $past(nextState))
    else $error("next state not loaded");
  AST_RSTQ: assert property (!resetDone |-> cellQ == 8'h00)
    else $error("cell not low during power-up");
  AST_RSTTIME: assert property ($fell(rst) |-> ##[1:101] resetDone)
    else $error("power-up reset too slow");
  AST_PINHI: assert property (!resetDone |-> pinOut == 8'hFF)
    else $error("pin not high during power-up");
  AST_PULL: assert property (1'b1 |=> pinRead == ($past(pinIn) | ~$past(pinDriven)))
    else $error("floating pin not read high");
  AST_REFUSE: assert property (rdReq.cfgRead && !rdReq.sigRead && secured |=>
    rdRefused && !rdValid && rdData == 32'h0000_0000) else $error("protected read answered");
  AST_SIGOK: assert property (rdReq.sigRead |=> rdValid && !rdRefused)
    else $error("signature read refused");
  AST_BUSY: assert property ($rose(progBusy) |-> busySpan ##1 !progBusy)
    else $error("programming cycle length wrong");
  AST_LOCK: assert property ($past(secured) && !progBusy && !$past(progBusy) |-> secured)
    else $error("protection cleared outside programming");
endmodule : pri_core_props

// ===== tb/pri_programmer.sv
// Programmer model that runs whole programming cycles on the core.
`timescale 1ns/1ps
module pri_programmer (
  input  wire logic          ref_clk,  // Clock.
  input  wire logic          progBusy, // Core busy.
  output pri_pkg::pri_prog_s prog      // Request.
);
  initial prog = '0;
  // No separate erase is sent; the core erases inside the cycle.
  task automatic run_cycle(input logic [3:0] a, input logic [31:0] d,
                           input logic [63:0] s, input logic sec, input int slow);
    int n;
    n = 0;
    repeat (slow + 1) @(negedge ref_clk);
    prog <= '{1'b1, a, d, s, sec};
    @(negedge ref_clk);
    prog.start <= 1'b0;
    while (progBusy !== 1'b0 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    // Released fields show garbage so a late sample cannot pass by luck.
    prog <= '{1'b0, ~a, ~d, ~s, ~sec};
  endtask : run_cycle
endmodule : pri_programmer

// ===== tb/pri_core_bench.sv
// Bench for the register init and protection core.
`timescale 1ns/1ps
module pri_core_bench;
  logic               ref_clk, rst, preloadEn, rdValid, rdRefused, progBusy, secured, resetDone;
  logic [7:0]         nextState, preloadVal, outEnable, pinIn, pinDriven;
  logic [7:0]         cellQ, pinOut, pinOe, pinRead;
  logic [31:0]        rdData, checksum;
  pri_pkg::pri_prog_s prog;
  pri_pkg::pri_read_s rdReq;
  int                 err_count = 0;
  int                 compares = 0;
  pri_core pri_core_inst (.ref_clk, .rst, .prog, .rdReq, .nextState, .preloadEn, .preloadVal,
    .outEnable, .pinIn, .pinDriven, .cellQ, .pinOut, .pinOe, .pinRead, .rdData, .rdValid,
    .rdRefused, .progBusy, .secured, .checksum, .resetDone);
  pri_programmer pri_programmer_inst (.ref_clk, .progBusy, .prog);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic rd(input logic c, input logic s, input logic [3:0] a, output logic [33:0] res);
    @(negedge ref_clk);
    rdReq = '{c, s, a};
    @(negedge ref_clk);
    res = {rdValid, rdRefused, rdData};
    rdReq = '0;
  endtask : rd
  task automatic t_power;
    int n;
    n = 0;
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    check(pinOut, 8'hFF);
    // Cell inputs stay still until the power-up count ends.
    while (resetDone !== 1'b1 && n < 120) begin
      @(negedge ref_clk);
      n++;
    end
    check(n <= pri_pkg::PWRUP_CYCLES, 1'b1);
    check(cellQ, 8'h00);
    check(pinOut, 8'hFF);
  endtask : t_power
  task automatic t_cells;
    preloadEn = 1'b1;
    preloadVal = 8'hA5;
    @(negedge ref_clk);
    check(cellQ, 8'hA5);
    check(pinOut, 8'h5A);
    check(pinOe, 8'hFF);
    preloadEn = 1'b0;
    nextState = 8'h3C;
    pinDriven = 8'h0F;
    pinIn = 8'h05;
    repeat (2) @(negedge ref_clk);
    check(cellQ, 8'h3C);
    check(pinRead, 8'hF5);
  endtask : t_cells
  task automatic t_prog;
    logic [33:0] r;
    logic [31:0] c1;
    pri_programmer_inst.run_cycle(4'h3, 32'h1234_5678, 64'h0123_4567_89AB_CDEF, 1'b0, 0);
    check(progBusy, 1'b0);
    rd(1'b1, 1'b0, 4'h3, r);
    check(r, {2'h2, 32'h1234_5678});
    rd(1'b0, 1'b1, 4'h1, r);
    check(r, {2'h2, 32'h0123_4567});
    c1 = checksum;
    pri_programmer_inst.run_cycle(4'h3, 32'h1234_5678, 64'h0123_4567_89AB_CDEE, 1'b1, 3);
    check(progBusy, 1'b0);
    // The checksum register follows the written contents one edge later.
    @(negedge ref_clk);
    check(checksum != c1, 1'b1);
    rd(1'b1, 1'b0, 4'h3, r);
    check(r, {2'h1, 32'h0000_0000});
    rd(1'b1, 1'b1, 4'h0, r);
    check(r, {2'h2, 32'h89AB_CDEE});
    t_power();
    check(secured, 1'b1);
    pri_programmer_inst.run_cycle(4'h5, 32'h0000_0001, 64'h0000_0000_0000_0000, 1'b0, 1);
    check(progBusy, 1'b0);
    check(secured, 1'b0);
    rd(1'b1, 1'b0, 4'h3, r);
    check(r, {2'h2, 32'h0000_0000});
  endtask : t_prog
  initial begin
    // Every input settles before the first clock edge.
    {preloadEn, preloadVal, nextState, pinIn, pinDriven} = '0;
    outEnable = 8'hFF;
    rdReq = '0;
    t_power();
    t_cells();
    t_prog();
    wrap_up();
  end
  // About 280 cycles are needed, two power-up counts included; the watchdog allows 6,000.
  initial begin
    #60000;
    err_count++;
    wrap_up();
  end
endmodule : pri_core_bench
bind pri_core pri_core_props pri_core_props_inst (.ref_clk, .rst, .rdReq, .nextState,
  .preloadEn, .preloadVal, .pinIn, .pinDriven, .cellQ, .pinOut, .pinRead, .rdData, .rdValid,
  .rdRefused, .progBusy, .secured, .resetDone);
